// ===== rtl/csr_pkg.sv
// package for the cpu complex control register block
// assumes one 20 MHz core clock and a plain address/strobe register port
package csr_pkg;
    // ********************
    // widths
    // ********************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TMR_W  = 16;
    localparam int NUM_TGT = 4;
    // ********************
    // register offsets (byte addresses)
    // ********************
    localparam logic [7:0] OFS_USER_STAT   = 8'h00;
    localparam logic [7:0] OFS_EXT_STAT    = 8'h04;
    localparam logic [7:0] OFS_MCHK_STAT   = 8'h08;
    localparam logic [7:0] OFS_DBG_CTRL    = 8'h0c;
    localparam logic [7:0] OFS_DBG_STAT    = 8'h10;
    localparam logic [7:0] OFS_INSN_BUF    = 8'h14;
    localparam logic [7:0] OFS_DBG_DATA    = 8'h18;
    localparam logic [7:0] OFS_BOOT_ADDR   = 8'h1c;
    localparam logic [7:0] OFS_PRIO_CTRL   = 8'h20;
    localparam logic [7:0] OFS_WDOG_VAL    = 8'h24;
    localparam logic [7:0] OFS_HPRI_VAL    = 8'h28;
    localparam logic [7:0] OFS_WDOG_CNT    = 8'h2c;
    localparam logic [7:0] OFS_SHADOW_INT  = 8'h30;
    localparam logic [7:0] OFS_ERR_ADDR    = 8'h34;
    localparam logic [7:0] OFS_RXQ_MASTER  = 8'h38;
    localparam logic [7:0] OFS_RXQ_EN1     = 8'h3c;
    localparam logic [7:0] OFS_RXQ_EN2     = 8'h40;
    localparam logic [7:0] OFS_RXQ_UPPER   = 8'h44;
    localparam logic [7:0] OFS_RXQ_LOWER   = 8'h48;
    localparam logic [7:0] OFS_DMQ_MASTER  = 8'h4c;
    localparam logic [7:0] OFS_DMQ_EN      = 8'h50;
    localparam logic [7:0] OFS_RXQ_LEN     = 8'h54;
    localparam logic [7:0] OFS_DMQ_LEN     = 8'h58;
    localparam logic [7:0] OFS_STAT        = 8'h5c;
    localparam logic [7:0] OFS_INT_EN      = 8'h60;
    localparam logic [7:0] OFS_USER_INT_EN = 8'h64;
    localparam logic [7:0] OFS_EXT_INT_EN  = 8'h68;
    localparam logic [7:0] OFS_MCHK_EN     = 8'h6c;
    localparam logic [7:0] OFS_LOCK_EN     = 8'h70;
    localparam logic [7:0] OFS_USER_LOCK   = 8'h74;
    localparam logic [7:0] OFS_EVT_ENQ     = 8'h78;
    localparam logic [7:0] OFS_DMA_ENQ     = 8'h7c;
    localparam logic [7:0] OFS_EVT_DEQ     = 8'h80;
    localparam logic [7:0] OFS_HPRI_CNT    = 8'h84;
    // ********************
    // reset values and timing
    // ********************
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
    localparam logic [15:0] RST_TMR_VAL   = 16'hffff;
    localparam logic [31:0] RST_BOOT_ADDR = 32'hfff0_0000; // arbitrary default
    localparam real TICK_NS  = 7.5;
    localparam real CLK_NS   = 50.0;
    // a 7.5 ns tick is shorter than one 50 ns cycle: round, never below one
    localparam int TICK_CYC  = (int'(TICK_NS / CLK_NS) < 1) ? 1 : int'(TICK_NS / CLK_NS);
    // status bits of the block's own status register
    localparam int STB_WDOG = 0;  // bits 0..3 watchdog timeouts
    localparam int STB_HPRI = 4;  // bits 4..7 high-priority timeouts
endpackage : csr_pkg

// ===== rtl/csr_cpu_complex_regs.sv
// control, status, timers and mirrors around the embedded cpu complex
// assumes the register master and all unit inputs share core_clk
// Summary of operation
// - a started transaction loads its watchdog from the value register
// - watchdog counts down, stops on target response or at zero
// - watchdog reaching zero sets a status bit
// - watchdog zero acknowledges the stalled transaction back to requester
// - timers decrement once per 50 ns core clock cycle, one tick per cycle
// - timer value is 16 bits, all-ones gives the longest wait
// - separate high-priority timers load and count the same way
// - local mirror of chip interrupt source register
// - capture address of latest errored virtual write
// - mirror receive queue unit master, enabled, upper, lower status
// - mirror dma queue unit master and enabled status
// - queue length reads return lengths from the addressed unit
// - pci interrupt when any enabled status bit is set
// - user status bit interrupts only while its enable is set
// - core interrupt from external status and core enable
// - machine check from machine-check status and its enable
// - status bit with lock enable holds state machines idle
// - user status bits lock the same way via user lock enable
// - writes to enqueue locations enqueue an event or a dma request
// - read of dequeue location pops one event and returns it
// - core boots from the boot address register
// - debug buffer writes are inserted into the core for execution
`timescale 1ns/10ps
module csr_cpu_complex_regs #(
    parameter int NTGT = csr_pkg::NUM_TGT
) (
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    input  wire logic [csr_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic [csr_pkg::DATA_W-1:0]    regWrData,
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    output logic      [csr_pkg::DATA_W-1:0]    regRdData,
    input  wire logic [NTGT-1:0]               txnStart,
    input  wire logic [NTGT-1:0]               txnHighPri,
    input  wire logic [NTGT-1:0]               txnRespond,
    output logic      [NTGT-1:0]               txnBrokenAck,
    input  wire logic [31:0]                   chipInterruptSource,
    input  wire logic                          virtWriteError,
    input  wire logic [31:0]                   virtWriteAddr,
    input  wire logic [31:0]                   rxqMasterStat,
    input  wire logic [31:0]                   rxqEnStat1,
    input  wire logic [31:0]                   rxqEnStat2,
    input  wire logic [31:0]                   rxqUpperStat,
    input  wire logic [31:0]                   rxqLowerStat,
    input  wire logic [31:0]                   dmqMasterStat,
    input  wire logic [31:0]                   dmqEnStat,
    input  wire logic [31:0]                   rxqQueueLen,
    input  wire logic [31:0]                   dmqQueueLen,
    input  wire logic [31:0]                   extStatusSet,
    input  wire logic [31:0]                   mchkStatusSet,
    input  wire logic [31:0]                   dbgStatus,
    output logic                               evtEnqValid,
    output logic                               dmaEnqValid,
    output logic      [31:0]                   enqData,
    output logic                               evtDeqPop,
    input  wire logic [31:0]                   evtDeqData,
    output logic                               pciIntReq,
    output logic                               coreIntReq,
    output logic                               coreMchkReq,
    output logic                               lockIdle,
    output logic      [31:0]                   bootAddr,
    output logic      [31:0]                   accessPrio,
    output logic      [31:0]                   dbgControl,
    output logic      [31:0]                   dbgDataOut,
    output logic      [31:0]                   insnStuff,
    output logic                               insnStuffValid
);
    import csr_pkg::*;

    // ********************
    // address decode
    // ********************
    wire wrUser    = regWrite && regAddr == OFS_USER_STAT;
    wire wrExt     = regWrite && regAddr == OFS_EXT_STAT;
    wire wrMchk    = regWrite && regAddr == OFS_MCHK_STAT;
    wire wrStat    = regWrite && regAddr == OFS_STAT;
    wire wrEvtEnq  = regWrite && regAddr == OFS_EVT_ENQ;
    wire wrDmaEnq  = regWrite && regAddr == OFS_DMA_ENQ;
    wire wrInsn    = regWrite && regAddr == OFS_INSN_BUF;
    wire rdEvtDeq  = regRead && regAddr == OFS_EVT_DEQ;

    logic [31:0] userStat;
    logic [31:0] extStat;
    logic [31:0] mchkStat;
    logic [31:0] stat;
    logic [31:0] intEn;
    logic [31:0] userIntEn;
    logic [31:0] extIntEn;
    logic [31:0] mchkEn;
    logic [31:0] lockEn;
    logic [31:0] userLockEn;
    logic [31:0] shadowInt;
    logic [31:0] errAddr;
    logic [31:0] dbgData;
    logic [TMR_W-1:0] wdogVal;
    logic [TMR_W-1:0] hpriVal;
    logic [NTGT-1:0][TMR_W-1:0] wdogCnt;
    logic [NTGT-1:0][TMR_W-1:0] hpriCnt;
    logic [NTGT-1:0] wdogRun;
    logic [NTGT-1:0] hpriRun;
    logic [NTGT-1:0] wdogExp;
    logic [NTGT-1:0] hpriExp;

    // ********************
    // interrupt and lock combination
    // ********************
    assign pciIntReq   = |(stat & intEn);
    assign coreIntReq  = |(extStat & extIntEn) | |(userStat & userIntEn);
    assign coreMchkReq = |(mchkStat & mchkEn);
    assign lockIdle    = |(stat & lockEn) | |(userStat & userLockEn);

    // ********************
    // transaction timers
    // ********************
    // one 50 ns cycle is more than one tick; every cycle counts one tick
    localparam logic [TMR_W-1:0] TMR_DEC = TMR_W'(TICK_CYC);
    genvar g;
    generate
        for (g = 0; g < NTGT; g++) begin : gTmr
            wire ldW = txnStart[g] && !txnHighPri[g] && !lockIdle;
            wire ldH = txnStart[g] && txnHighPri[g] && !lockIdle;
            wire hitW = wdogRun[g] && !txnRespond[g] && wdogCnt[g] <= TMR_DEC;
            wire hitH = hpriRun[g] && !txnRespond[g] && hpriCnt[g] <= TMR_DEC;
            assign wdogExp[g] = hitW;
            assign hpriExp[g] = hitH;
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    wdogCnt[g] <= '0;
                    wdogRun[g] <= 1'b0;
                end else if (ldW) begin
                    wdogCnt[g] <= wdogVal;
                    wdogRun[g] <= 1'b1;
                end else if (wdogRun[g]) begin
                    if (txnRespond[g] || hitW) begin
                        wdogRun[g] <= 1'b0;
                        wdogCnt[g] <= hitW ? '0 : wdogCnt[g];
                    end else begin
                        wdogCnt[g] <= wdogCnt[g] - TMR_DEC;
                    end
                end
            end
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    hpriCnt[g] <= '0;
                    hpriRun[g] <= 1'b0;
                end else if (ldH) begin
                    hpriCnt[g] <= hpriVal;
                    hpriRun[g] <= 1'b1;
                end else if (hpriRun[g]) begin
                    if (txnRespond[g] || hitH) begin
                        hpriRun[g] <= 1'b0;
                        hpriCnt[g] <= hitH ? '0 : hpriCnt[g];
                    end else begin
                        hpriCnt[g] <= hpriCnt[g] - TMR_DEC;
                    end
                end
            end
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    txnBrokenAck[g] <= 1'b0;
                end else begin
                    txnBrokenAck[g] <= hitW || hitH;
                end
            end
        end
    endgenerate

    // ********************
    // status registers except user status: write one to clear, hardware set wins
    // ********************
    wire [31:0] statSet = 32'({hpriExp, wdogExp});
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stat     <= RST_ZERO;
            extStat  <= RST_ZERO;
            mchkStat <= RST_ZERO;
            userStat <= RST_ZERO;
        end else begin
            stat     <= (stat & ~(wrStat ? regWrData : 32'h0)) | statSet;
            extStat  <= (extStat & ~(wrExt ? regWrData : 32'h0)) | extStatusSet;
            mchkStat <= (mchkStat & ~(wrMchk ? regWrData : 32'h0)) | mchkStatusSet;
            // user status is software defined: a write stores it directly
            userStat <= wrUser ? regWrData : userStat;
        end
    end

    // ********************
    // control registers and mirrors
    // ********************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            intEn      <= RST_ZERO;
            userIntEn  <= RST_ZERO;
            extIntEn   <= RST_ZERO;
            mchkEn     <= RST_ZERO;
            lockEn     <= RST_ZERO;
            userLockEn <= RST_ZERO;
            wdogVal    <= RST_TMR_VAL;
            hpriVal    <= RST_TMR_VAL;
            bootAddr   <= RST_BOOT_ADDR;
            accessPrio <= RST_ZERO;
            dbgControl <= RST_ZERO;
            dbgData    <= RST_ZERO;
        end else if (regWrite) begin
            if (regAddr == OFS_INT_EN) begin
                intEn <= regWrData;
            end else if (regAddr == OFS_USER_INT_EN) begin
                userIntEn <= regWrData;
            end else if (regAddr == OFS_EXT_INT_EN) begin
                extIntEn <= regWrData;
            end else if (regAddr == OFS_MCHK_EN) begin
                mchkEn <= regWrData;
            end else if (regAddr == OFS_LOCK_EN) begin
                lockEn <= regWrData;
            end else if (regAddr == OFS_USER_LOCK) begin
                userLockEn <= regWrData;
            end else if (regAddr == OFS_WDOG_VAL) begin
                wdogVal <= regWrData[TMR_W-1:0];
            end else if (regAddr == OFS_HPRI_VAL) begin
                hpriVal <= regWrData[TMR_W-1:0];
            end else if (regAddr == OFS_BOOT_ADDR) begin
                bootAddr <= regWrData;
            end else if (regAddr == OFS_PRIO_CTRL) begin
                accessPrio <= regWrData;
            end else if (regAddr == OFS_DBG_CTRL) begin
                dbgControl <= regWrData;
            end else if (regAddr == OFS_DBG_DATA) begin
                dbgData <= regWrData;
            end
        end
    end
    assign dbgDataOut = dbgData;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            shadowInt <= RST_ZERO;
            errAddr   <= RST_ZERO;
        end else begin
            shadowInt <= chipInterruptSource;
            if (virtWriteError) begin
                errAddr <= virtWriteAddr;
            end
        end
    end

    // ********************
    // enqueue, dequeue and debug stuffing
    // ********************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            evtEnqValid    <= 1'b0;
            dmaEnqValid    <= 1'b0;
            enqData        <= RST_ZERO;
            insnStuff      <= RST_ZERO;
            insnStuffValid <= 1'b0;
        end else begin
            evtEnqValid    <= wrEvtEnq;
            dmaEnqValid    <= wrDmaEnq;
            insnStuffValid <= wrInsn;
            if (wrEvtEnq || wrDmaEnq) begin
                enqData <= regWrData;
            end
            if (wrInsn) begin
                insnStuff <= regWrData;
            end
        end
    end
    // pop is combinational so the event lands in the same read answer
    assign evtDeqPop = rdEvtDeq;

    // ********************
    // read mux
    // ********************
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0;
        if (regAddr == OFS_USER_STAT) rdMux = userStat;
        else if (regAddr == OFS_EXT_STAT) rdMux = extStat;
        else if (regAddr == OFS_MCHK_STAT) rdMux = mchkStat;
        else if (regAddr == OFS_DBG_CTRL) rdMux = dbgControl;
        else if (regAddr == OFS_DBG_STAT) rdMux = dbgStatus;
        else if (regAddr == OFS_INSN_BUF) rdMux = insnStuff;
        else if (regAddr == OFS_DBG_DATA) rdMux = dbgData;
        else if (regAddr == OFS_BOOT_ADDR) rdMux = bootAddr;
        else if (regAddr == OFS_PRIO_CTRL) rdMux = accessPrio;
        else if (regAddr == OFS_WDOG_VAL) rdMux = {16'h0, wdogVal};
        else if (regAddr == OFS_HPRI_VAL) rdMux = {16'h0, hpriVal};
        else if (regAddr == OFS_WDOG_CNT) rdMux = {16'h0, wdogCnt[0]};
        else if (regAddr == OFS_HPRI_CNT) rdMux = {16'h0, hpriCnt[0]};
        else if (regAddr == OFS_SHADOW_INT) rdMux = shadowInt;
        else if (regAddr == OFS_ERR_ADDR) rdMux = errAddr;
        else if (regAddr == OFS_RXQ_MASTER) rdMux = rxqMasterStat;
        else if (regAddr == OFS_RXQ_EN1) rdMux = rxqEnStat1;
        else if (regAddr == OFS_RXQ_EN2) rdMux = rxqEnStat2;
        else if (regAddr == OFS_RXQ_UPPER) rdMux = rxqUpperStat;
        else if (regAddr == OFS_RXQ_LOWER) rdMux = rxqLowerStat;
        else if (regAddr == OFS_DMQ_MASTER) rdMux = dmqMasterStat;
        else if (regAddr == OFS_DMQ_EN) rdMux = dmqEnStat;
        else if (regAddr == OFS_RXQ_LEN) rdMux = rxqQueueLen;
        else if (regAddr == OFS_DMQ_LEN) rdMux = dmqQueueLen;
        else if (regAddr == OFS_STAT) rdMux = stat;
        else if (regAddr == OFS_INT_EN) rdMux = intEn;
        else if (regAddr == OFS_USER_INT_EN) rdMux = userIntEn;
        else if (regAddr == OFS_EXT_INT_EN) rdMux = extIntEn;
        else if (regAddr == OFS_MCHK_EN) rdMux = mchkEn;
        else if (regAddr == OFS_LOCK_EN) rdMux = lockEn;
        else if (regAddr == OFS_USER_LOCK) rdMux = userLockEn;
        else if (regAddr == OFS_EVT_DEQ) rdMux = evtDeqData;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            regRdData <= RST_ZERO;
        end else begin
            regRdData <= regRead ? rdMux : RST_ZERO;
        end
    end
endmodule : csr_cpu_complex_regs

// ===== test/csr_cpu_complex_regs_properties.sv
// port-level checker for the cpu complex register block
// assumes one core clock, synchronous reset and the package offsets
`timescale 1ns/10ps
module csr_cpu_complex_regs_properties
    import csr_pkg::*;
#(
    parameter int NTGT = csr_pkg::NUM_TGT
) (
    input wire logic                        core_clk,
    input wire logic                        reset,
    input wire logic [csr_pkg::ADDR_W-1:0]  regAddr,
    input wire logic [csr_pkg::DATA_W-1:0]  regWrData,
    input wire logic                        regWrite,
    input wire logic                        regRead,
    input wire logic [csr_pkg::DATA_W-1:0]  regRdData,
    input wire logic [NTGT-1:0]             txnRespond,
    input wire logic [NTGT-1:0]             txnBrokenAck,
    input wire logic [31:0]                 chipInterruptSource,
    input wire logic [31:0]                 rxqMasterStat,
    input wire logic                        evtEnqValid,
    input wire logic                        dmaEnqValid,
    input wire logic [31:0]                 enqData,
    input wire logic                        evtDeqPop,
    input wire logic [31:0]                 evtDeqData,
    input wire logic [31:0]                 bootAddr,
    input wire logic [31:0]                 insnStuff,
    input wire logic                        insnStuffValid
);
    // ********************
    // assertions
    // ********************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    evt_enqueue_a: assert property (
        regWrite && regAddr == OFS_EVT_ENQ |=> evtEnqValid && enqData == $past(regWrData))
        else $error("event enqueue pulse or data wrong");
    dma_enqueue_a: assert property (
        regWrite && regAddr == OFS_DMA_ENQ |=> dmaEnqValid && enqData == $past(regWrData))
        else $error("dma enqueue pulse or data wrong");
    event_pop_a: assert property (
        regRead && regAddr == OFS_EVT_DEQ |-> evtDeqPop ##1 regRdData == $past(evtDeqData))
        else $error("dequeue pop or returned event wrong");
    boot_write_a: assert property (
        regWrite && regAddr == OFS_BOOT_ADDR |=> bootAddr == $past(regWrData))
        else $error("boot address not taken from write");
    insn_stuff_a: assert property (
        regWrite && regAddr == OFS_INSN_BUF |=> insnStuffValid && insnStuff == $past(regWrData))
        else $error("stuffed instruction not passed to core");
    rxq_mirror_a: assert property (
        regRead && regAddr == OFS_RXQ_MASTER |=> regRdData == $past(rxqMasterStat))
        else $error("receive queue master status mirror wrong");
    // stable source only: the mirror lags its source by one cycle
    shadow_int_a: assert property (
        regRead && regAddr == OFS_SHADOW_INT && $stable(chipInterruptSource)
        |=> regRdData == $past(chipInterruptSource))
        else $error("interrupt source mirror wrong");
    resp_stop_a: assert property (
        txnRespond[0] |=> ##1 !txnBrokenAck[0])
        else $error("timeout after target answered");
endmodule : csr_cpu_complex_regs_properties

bind csr_cpu_complex_regs csr_cpu_complex_regs_properties #(.NTGT(NTGT)) props (
    .core_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .txnRespond, .txnBrokenAck, .chipInterruptSource, .rxqMasterStat, .evtEnqValid,
    .dmaEnqValid, .enqData, .evtDeqPop, .evtDeqData, .bootAddr, .insnStuff, .insnStuffValid
);

// ===== test/csr_unit_model.sv
// far side model: target answers and the event queue's dequeue data
// assumes one core clock; a delay of zero means the target never answers
`timescale 1ns/10ps
module csr_unit_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [3:0]  txnStart,
    input  wire logic [7:0]  respDelay,
    output logic      [3:0]  txnRespond,
    input  wire logic        evtDeqPop,
    output logic      [31:0] evtDeqData
);
    logic [7:0] waitCnt [4];
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            txnRespond[i] <= 1'b0;
            if (reset || txnStart[i]) begin
                waitCnt[i] <= reset ? 8'h00 : respDelay;
            end else if (waitCnt[i] != 8'h00) begin
                waitCnt[i] <= waitCnt[i] - 8'h01;
                txnRespond[i] <= (waitCnt[i] == 8'h01);
            end
        end
        // each pop moves on to a fresh event, so a stale read shows
        evtDeqData <= reset ? 32'h0000_a000 : evtDeqData + {31'h0, evtDeqPop};
    end
endmodule : csr_unit_model

// ===== test/csr_cpu_complex_regs_bench.sv
// self-checking bench for the cpu complex register block
// assumes the unit model on the far side and a 50 ns core clock
`timescale 1ns/10ps
module csr_cpu_complex_regs_bench;
    import csr_pkg::*;
    logic        core_clk, reset, regWrite, regRead, virtWriteError, evtEnqValid, dmaEnqValid;
    logic        evtDeqPop, pciIntReq, coreIntReq, coreMchkReq, lockIdle, insnStuffValid;
    logic [7:0]  regAddr, respDelay, offs [11];
    logic [3:0]  txnStart, txnHighPri, txnRespond, txnBrokenAck;
    logic [31:0] regWrData, regRdData, virtWriteAddr, extStatusSet, mchkStatusSet, evtDeqData;
    logic [31:0] enqData, bootAddr, accessPrio, insnStuff, dbgCtl, dbgOut, rd, src [11];
    int          nErrors, comparisons, n;
    csr_cpu_complex_regs #(.NTGT(4)) DUT (.core_clk, .reset, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData, .txnStart, .txnHighPri, .txnRespond, .txnBrokenAck,
        .chipInterruptSource(src[9]), .virtWriteError, .virtWriteAddr,
        .rxqMasterStat(src[0]), .rxqEnStat1(src[1]), .rxqEnStat2(src[2]),
        .rxqUpperStat(src[3]), .rxqLowerStat(src[4]), .dmqMasterStat(src[5]),
        .dmqEnStat(src[6]), .rxqQueueLen(src[7]), .dmqQueueLen(src[8]), .extStatusSet,
        .mchkStatusSet, .dbgStatus(src[10]), .evtEnqValid, .dmaEnqValid, .enqData, .evtDeqPop,
        .evtDeqData, .pciIntReq, .coreIntReq, .coreMchkReq, .lockIdle, .bootAddr, .accessPrio,
        .dbgControl(dbgCtl), .dbgDataOut(dbgOut), .insnStuff, .insnStuffValid);
    csr_unit_model model (.core_clk, .reset, .txnStart, .respDelay, .txnRespond, .evtDeqPop,
        .evtDeqData);
    // ********************
    // bus and comparison tasks
    // ********************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrite  <= 1'b0;
        #1;
    endtask : wr
    task automatic rdReg(input logic [7:0] a);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 rd = regRdData;
    endtask : rdReg
    // bounded wait: 40 means no timeout acknowledge was seen
    task automatic runTimer(input int t, input logic hp, input logic [7:0] dly, input int exp);
        @(posedge core_clk);
        txnStart[t]   <= 1'b1;
        txnHighPri[t] <= hp;
        respDelay     <= dly;
        @(posedge core_clk);
        txnStart[t]   <= 1'b0;
        #1;
        for (n = 1; n < 40 && txnBrokenAck[t] !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        check(n, exp);
    endtask : runTimer
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    // ********************
    // scenarios
    // ********************
    task automatic testMapAndMirrors;
        rdReg(OFS_BOOT_ADDR);
        check(rd, RST_BOOT_ADDR);
        rdReg(OFS_WDOG_VAL);
        check(rd, {16'h0, RST_TMR_VAL});
        rdReg(8'hfc);
        check(rd, 32'h0);
        wr(OFS_BOOT_ADDR, 32'h0000_4100);
        check(bootAddr, 32'h0000_4100);
        wr(OFS_PRIO_CTRL, 32'h0000_0003);
        check(accessPrio, 32'h0000_0003);
        for (int k = 0; k < 11; k++) begin
            rdReg(offs[k]);
            check(rd, src[k]);
        end
        @(posedge core_clk);
        virtWriteError <= 1'b1;
        virtWriteAddr  <= 32'h0012_3400;
        @(posedge core_clk);
        virtWriteAddr  <= 32'h0056_7800;
        @(posedge core_clk);
        virtWriteError <= 1'b0;
        rdReg(OFS_ERR_ADDR);
        check(rd, 32'h0056_7800);
        $display("map and mirrors done");
    endtask : testMapAndMirrors
    task automatic testTimers;
        wr(OFS_WDOG_VAL, 32'h8);
        runTimer(0, 1'b0, 8'h00, 9);
        rdReg(OFS_STAT);
        check(rd, 32'h1);
        runTimer(0, 1'b0, 8'h03, 40);
        wr(OFS_HPRI_VAL, 32'h5);
        runTimer(1, 1'b1, 8'h00, 6);
        rdReg(OFS_STAT);
        check(rd, 32'h21);
        $display("timers done");
    endtask : testTimers
    task automatic testInterrupts;
        wr(OFS_INT_EN, 32'h1);
        check(pciIntReq, 32'h1);
        wr(OFS_INT_EN, 32'h2);
        check(pciIntReq, 32'h0);
        @(posedge core_clk);
        extStatusSet  <= 32'h8;
        mchkStatusSet <= 32'h4;
        @(posedge core_clk);
        extStatusSet  <= 32'h0;
        mchkStatusSet <= 32'h0;
        wr(OFS_EXT_INT_EN, 32'h8);
        check(coreIntReq, 32'h1);
        wr(OFS_MCHK_EN, 32'h4);
        check(coreMchkReq, 32'h1);
        wr(OFS_EXT_STAT, 32'h8);
        check(coreIntReq, 32'h0);
        wr(OFS_USER_STAT, 32'h1);
        wr(OFS_USER_INT_EN, 32'h1);
        check(coreIntReq, 32'h1);
        wr(OFS_USER_INT_EN, 32'h0);
        check(coreIntReq, 32'h0);
        wr(OFS_USER_LOCK, 32'h1);
        check(lockIdle, 32'h1);
        wr(OFS_USER_LOCK, 32'h0);
        wr(OFS_LOCK_EN, 32'h1);
        check(lockIdle, 32'h1);
        runTimer(0, 1'b0, 8'h00, 40);
        wr(OFS_LOCK_EN, 32'h0);
        check(lockIdle, 32'h0);
        $display("interrupts and locks done");
    endtask : testInterrupts
    task automatic testQueues;
        wr(OFS_EVT_ENQ, 32'h0000_0e01);
        check({evtEnqValid, enqData[30:0]}, 32'h8000_0e01);
        wr(OFS_DMA_ENQ, 32'h0000_0d02);
        check({dmaEnqValid, enqData[30:0]}, 32'h8000_0d02);
        rdReg(OFS_EVT_DEQ);
        check(rd, 32'h0000_a000);
        rdReg(OFS_EVT_DEQ);
        check(rd, 32'h0000_a001);
        wr(OFS_INSN_BUF, 32'h0000_7c01);
        check({insnStuffValid, insnStuff[30:0]}, 32'h8000_7c01);
        wr(OFS_DBG_CTRL, 32'h0000_0c05);
        wr(OFS_DBG_DATA, 32'h0000_0d06);
        check({dbgCtl[15:0], dbgOut[15:0]}, 32'h0c05_0d06);
        $display("queues and debug done");
    endtask : testQueues
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        {reset, regWrite, regRead, virtWriteError} = 4'h8;
        {regAddr, respDelay, txnStart, txnHighPri} = '0;
        {regWrData, virtWriteAddr, extStatusSet, mchkStatusSet} = '0;
        offs = '{OFS_RXQ_MASTER, OFS_RXQ_EN1, OFS_RXQ_EN2, OFS_RXQ_UPPER, OFS_RXQ_LOWER,
            OFS_DMQ_MASTER, OFS_DMQ_EN, OFS_RXQ_LEN, OFS_DMQ_LEN, OFS_SHADOW_INT, OFS_DBG_STAT};
        for (int k = 0; k < 11; k++) src[k] = 32'h5a30_0000 + 32'(k * 17);
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        testMapAndMirrors();
        testTimers();
        testInterrupts();
        testQueues();
        summarize();
    end
endmodule : csr_cpu_complex_regs_bench
